// ### include/tpfpc_pkg.sv
// shared constants and types for the three-port fifo port control block
// assumes the block runs on one system clock that samples all port pins
package tpfpc_pkg;
   localparam int A_W          = 36;   // port a bus width
   localparam int BC_W         = 18;   // port b and port c bus width
   localparam int OFS_AW       = 11;   // offset register width, one fifo address width
   localparam int OFS_REGS     = 4;    // offset registers in the serial chain
   localparam int PARITY_BIT   = 8;    // port a bit skipped under interspersed parity
   localparam int FIFO_DEPTH   = 8;    // words held in each fifo
   localparam int CTRL_SYNC_W  = 19;   // control pins passing the pin synchroniser
   localparam int OFS_Y1       = 0;    // chain position of fifo one almost-full offset
   localparam int OFS_X1       = 1;    // chain position of fifo one almost-empty offset
   localparam int OFS_Y2       = 2;    // chain position of fifo two almost-full offset
   localparam int OFS_X2       = 3;    // chain position of fifo two almost-empty offset
   localparam int OFS_RST      = 1;    // offset value after reset

   // offset programming progress
   typedef enum logic [1:0] {
      PROG_WAIT     = 2'b00,
      PROG_SERIAL   = 2'b01,
      PROG_PARALLEL = 2'b10,
      PROG_DONE     = 2'b11
   } tpfpc_prog_e;

   // port a control pins
   typedef struct packed {
      logic port_a_select_n;
      logic port_a_direction;
      logic port_a_transfer_gate;
      logic port_a_mailbox_select;
   } tpfpc_porta_ctl_s;

   // flag programming pins, sampled at master reset release
   typedef struct packed {
      logic flag_select_high;
      logic offset_serial_data;
      logic offset_serial_gate_n;
   } tpfpc_ofs_pins_s;
endpackage

// ### hdl/tpfpc_top.sv
// port control for a dual-fifo, three-port buffer with mailboxes and loopback
// assumes port clocks are slow against i_mclk (at least four mclk per half period)
// and that pin data is stable around each rising port clock
`timescale 1ns/1ns

// fifo of parameterised width and depth, head word visible while valid
module tpfpc_fifo #(
   parameter int W = 18,
   parameter int D = 8
) (
   // clock and clear
   input  wire logic         i_clk,
   input  wire logic         i_rst,
   // write side
   input  wire logic         i_wr_valid,
   output logic              o_wr_ready,
   input  wire logic [W-1:0] i_wr_data,
   // read side
   output logic              o_rd_valid,
   input  wire logic         i_rd_ready,
   output logic [W-1:0]      o_rd_data,
   output logic [$clog2(D):0] o_count
);
   localparam int PW = (D > 1) ? $clog2(D) : 1;
   localparam logic [PW-1:0]       LAST_PTR = PW'(D - 1);
   localparam logic [$clog2(D):0]  FULL_CNT = ($clog2(D) + 1)'(D);

   logic [W-1:0]        mem_ff [D];
   logic [PW-1:0]       wr_ptr_ff;
   logic [PW-1:0]       rd_ptr_ff;
   logic [$clog2(D):0]  cnt_ff;
   logic                push;
   logic                pop;

   // ready drops honestly at full so the source sees back-pressure
   assign o_wr_ready = (cnt_ff != FULL_CNT);
   assign o_rd_valid = (cnt_ff != '0);
   assign o_rd_data  = mem_ff[rd_ptr_ff];
   assign o_count    = cnt_ff;
   assign push       = i_wr_valid && o_wr_ready;
   assign pop        = o_rd_valid && i_rd_ready;

   // storage has no reset, only pointers and count need a defined value
   always_ff @(posedge i_clk) begin
      if (push) begin
         mem_ff[wr_ptr_ff] <= i_wr_data;
      end
   end

   // pointers wrap at the last slot so depth need not be a power of two
   always_ff @(posedge i_clk) begin
      if (i_rst) begin
         wr_ptr_ff <= '0;
         rd_ptr_ff <= '0;
         cnt_ff    <= '0;
      end else begin
         if (push) begin
            wr_ptr_ff <= (wr_ptr_ff == LAST_PTR) ? '0 : wr_ptr_ff + 1'b1;
         end
         if (pop) begin
            rd_ptr_ff <= (rd_ptr_ff == LAST_PTR) ? '0 : rd_ptr_ff + 1'b1;
         end
         if (push && !pop) begin
            cnt_ff <= cnt_ff + 1'b1;
         end else if (pop && !push) begin
            cnt_ff <= cnt_ff - 1'b1;
         end
      end
   end
endmodule

module tpfpc_top #(
   parameter int OFS_W = tpfpc_pkg::OFS_AW,
   parameter int DEPTH = tpfpc_pkg::FIFO_DEPTH
) (
   // system clock and reset
   input  wire logic                          i_mclk,
   input  wire logic                          i_sys_rst,
   // port a
   input  wire logic                          i_port_a_clock,
   input  wire tpfpc_pkg::tpfpc_porta_ctl_s   i_port_a_ctl,
   input  wire logic                          i_wrap_select_n,
   input  wire logic                          i_timing_mode_select,
   input  wire logic [tpfpc_pkg::A_W-1:0]     i_port_a_data,
   output logic [tpfpc_pkg::A_W-1:0]          o_port_a_data,
   output logic                               o_port_a_data_oe_n,
   // port b
   input  wire logic                          i_port_b_clock,
   input  wire logic                          i_port_b_select_n,
   input  wire logic                          i_port_b_read_gate,
   input  wire logic                          i_port_b_mailbox_select,
   output logic [tpfpc_pkg::BC_W-1:0]         o_port_b_data,
   output logic                               o_port_b_data_oe_n,
   // port c
   input  wire logic                          i_port_c_clock,
   input  wire logic                          i_port_c_write_gate,
   input  wire logic                          i_port_c_mailbox_select,
   input  wire logic [tpfpc_pkg::BC_W-1:0]    i_port_c_data,
   // master resets and flag programming pins
   input  wire logic                          i_fifo_one_master_reset_n,
   input  wire logic                          i_fifo_two_master_reset_n,
   input  wire tpfpc_pkg::tpfpc_ofs_pins_s    i_ofs_pins,
   // status
   output logic                               o_fifo_one_input_ready,
   output logic                               o_fifo_two_input_ready,
   output logic                               o_fifo_one_output_ready,
   output logic                               o_fifo_two_output_ready,
   output logic                               o_mailbox_one_full_n,
   output logic                               o_mailbox_two_full_n,
   output logic                               o_fall_through_mode,
   output logic                               o_interspersed_parity_mode,
   output logic                               o_offsets_programmed,
   output logic [OFS_W-1:0]                   o_fifo_one_almost_full_offset,
   output logic [OFS_W-1:0]                   o_fifo_one_almost_empty_offset,
   output logic [OFS_W-1:0]                   o_fifo_two_almost_full_offset,
   output logic [OFS_W-1:0]                   o_fifo_two_almost_empty_offset
);
   import tpfpc_pkg::*;

   localparam int SYNC_W  = CTRL_SYNC_W + A_W + BC_W;
   localparam int CHAIN_W = OFS_REGS * OFS_W;
   localparam int SCNT_W  = $clog2(CHAIN_W + 1);
   localparam logic [SCNT_W-1:0] LAST_BIT = SCNT_W'(CHAIN_W - 1);
   localparam logic [1:0]        LAST_PAR = 2'(OFS_REGS - 1);
   localparam int CW = $clog2(DEPTH);

   // rising edge of a sampled port clock
   function automatic logic rise(input logic cur, input logic prev);
      rise = cur && !prev;
   endfunction

   // parallel offset word, parity bit dropped when interspersed
   function automatic logic [OFS_W-1:0] par_word(input logic [A_W-1:0] d, input logic ip);
      par_word = ip ? {d[OFS_W:PARITY_BIT+1], d[PARITY_BIT-1:0]} : d[OFS_W-1:0];
   endfunction

   logic [SYNC_W-1:0]   sync1_ff;
   logic [SYNC_W-1:0]   sync2_ff;
   logic                s_a_clk, s_b_clk, s_c_clk;
   tpfpc_porta_ctl_s    s_a;
   logic                s_wrap_n, s_tms, s_b_sel_n, s_b_gate, s_b_mbx;
   logic                s_c_gate, s_c_mbx, s_mr1_n, s_mr2_n;
   tpfpc_ofs_pins_s     s_ofs;
   logic [A_W-1:0]      s_a_data;
   logic [BC_W-1:0]     s_c_data;
   logic [2:0]          clk_prev_ff;
   logic [1:0]          mr_prev_ff;
   logic                a_edge, b_edge, c_edge, rst1, rst2;
   tpfpc_prog_e         prog_ff;
   logic [SCNT_W-1:0]   ser_cnt_ff;
   logic [1:0]          par_cnt_ff;
   logic [CHAIN_W-1:0]  ofs_ff;
   logic                ip_ff, fall_through_mode_ff, mode_pend_ff;
   logic                a_edge_d_ff, c_edge_d_ff, ok1_ff, done_ff;
   logic                ir1_ff, ir2_ff, rdy1_ff, rdy2_ff, pre1_ff, pre2_ff, seen2_ff;
   logic                mb1_n_ff, mb2_n_ff, oe_a_n_ff, oe_b_n_ff;
   logic [BC_W-1:0]     mb1_ff, mb2_ff, data_b_ff;
   logic [A_W-1:0]      data_a_ff;
   logic                a_sel, a_wr, a_rd, a_mb_wr, a_mb_rd, b_rd, b_mb_rd, c_wr, c_mb_wr;
   logic                wrap_go, f1_wr, f1_ready, f1_valid, f2_ready, f2_valid;
   logic                load1, load2, par_wr;
   logic [A_W-1:0]      f1_in, f1_head;
   logic [BC_W-1:0]     f2_head;
   logic [CW:0]         f1_cnt, f2_cnt;

   // every pin passes two flip-flops; only the second stage is unpacked and read
   always_ff @(posedge i_mclk) begin
      if (i_sys_rst) begin
         sync1_ff <= '0;
         sync2_ff <= '0;
      end else begin
         sync1_ff <= {i_port_a_clock, i_port_b_clock, i_port_c_clock, i_port_a_ctl,
                      i_wrap_select_n, i_timing_mode_select, i_port_b_select_n,
                      i_port_b_read_gate, i_port_b_mailbox_select, i_port_c_write_gate,
                      i_port_c_mailbox_select, i_fifo_one_master_reset_n,
                      i_fifo_two_master_reset_n, i_ofs_pins, i_port_a_data, i_port_c_data};
         sync2_ff <= sync1_ff;
      end
   end

   assign {s_a_clk, s_b_clk, s_c_clk, s_a, s_wrap_n, s_tms, s_b_sel_n, s_b_gate, s_b_mbx,
           s_c_gate, s_c_mbx, s_mr1_n, s_mr2_n, s_ofs, s_a_data, s_c_data} = sync2_ff;

   // edge finders for the three port clocks and the master resets
   always_ff @(posedge i_mclk) begin
      if (i_sys_rst) begin
         clk_prev_ff <= '0;
         mr_prev_ff  <= '0;
      end else begin
         clk_prev_ff <= {s_a_clk, s_b_clk, s_c_clk};
         mr_prev_ff  <= {s_mr1_n, s_mr2_n};
      end
   end

   assign a_edge = rise(s_a_clk, clk_prev_ff[2]);
   assign b_edge = rise(s_b_clk, clk_prev_ff[1]);
   assign c_edge = rise(s_c_clk, clk_prev_ff[0]);
   assign rst1   = i_sys_rst || !s_mr1_n;
   assign rst2   = i_sys_rst || !s_mr2_n;

   // port decodes, each qualified by its own port's edge only
   assign a_sel   = a_edge && !s_a.port_a_select_n && s_a.port_a_transfer_gate;
   assign wrap_go = a_sel && !s_wrap_n && !s_a.port_a_mailbox_select
                    && prog_ff == PROG_DONE;
   assign a_wr    = a_sel && s_wrap_n && s_a.port_a_direction
                    && !s_a.port_a_mailbox_select && ir1_ff;
   assign a_rd    = (a_sel && s_wrap_n && !s_a.port_a_direction
                    && !s_a.port_a_mailbox_select) || wrap_go;
   assign a_mb_wr = a_sel && s_a.port_a_direction && s_a.port_a_mailbox_select;
   assign a_mb_rd = a_sel && !s_a.port_a_direction && s_a.port_a_mailbox_select;
   assign b_rd    = b_edge && !s_b_sel_n && s_b_gate && !s_b_mbx;
   assign b_mb_rd = b_edge && !s_b_sel_n && s_b_gate && s_b_mbx;
   assign c_wr    = c_edge && s_c_gate && !s_c_mbx && ir2_ff;
   assign c_mb_wr = c_edge && s_c_gate && s_c_mbx;
   assign par_wr  = a_wr && prog_ff == PROG_PARALLEL;

   // output register loads: fall-through fills an empty register unasked
   // empty-flag mode moves a word only on a selected read
   assign load1 = f1_valid && (fall_through_mode_ff ? (b_edge && (!rdy1_ff || b_rd)) : (b_rd && rdy1_ff));
   assign load2 = f2_valid && (fall_through_mode_ff ? (a_edge && (!rdy2_ff || a_rd)) : (a_rd && rdy2_ff));

   // loopback writes the word leaving fifo two, or repeats the last one once drained
   assign f1_wr = (a_wr && prog_ff == PROG_DONE)
                  || (wrap_go && ir1_ff && (load2 || seen2_ff));
   assign f1_in = wrap_go ? (load2 ? {{(A_W-BC_W){1'b0}}, f2_head} : data_a_ff) : s_a_data;

   tpfpc_fifo #(.W(A_W), .D(DEPTH)) u_fifo_one (
      .i_clk      (i_mclk),
      .i_rst      (rst1),
      .i_wr_valid (f1_wr),
      .o_wr_ready (f1_ready),
      .i_wr_data  (f1_in),
      .o_rd_valid (f1_valid),
      .i_rd_ready (load1),
      .o_rd_data  (f1_head),
      .o_count    (f1_cnt)
   );

   tpfpc_fifo #(.W(BC_W), .D(DEPTH)) u_fifo_two (
      .i_clk      (i_mclk),
      .i_rst      (rst2),
      .i_wr_valid (c_wr && prog_ff == PROG_DONE),
      .o_wr_ready (f2_ready),
      .i_wr_data  (s_c_data),
      .o_rd_valid (f2_valid),
      .i_rd_ready (load2),
      .o_rd_data  (f2_head),
      .o_count    (f2_cnt)
   );

   // programming mode is chosen at fifo one reset release from the flag pins
   always_ff @(posedge i_mclk) begin
      if (i_sys_rst) begin
         prog_ff    <= PROG_WAIT;
         ip_ff      <= 1'b0;
         ser_cnt_ff <= '0;
         par_cnt_ff <= '0;
      end else if (!s_mr1_n) begin
         prog_ff    <= PROG_WAIT;
         ser_cnt_ff <= '0;
         par_cnt_ff <= '0;
      end else if (!mr_prev_ff[1]) begin
         ip_ff <= !s_ofs.flag_select_high && !s_ofs.offset_serial_gate_n
                  && !s_ofs.offset_serial_data;
         if (!s_ofs.flag_select_high && !s_ofs.offset_serial_data
             && s_ofs.offset_serial_gate_n) begin
            prog_ff <= PROG_SERIAL;
         end else if (!s_ofs.offset_serial_gate_n && !s_ofs.offset_serial_data) begin
            prog_ff <= PROG_PARALLEL;
         end else begin
            prog_ff <= PROG_DONE;
         end
      end else if (prog_ff == PROG_SERIAL && a_edge && !s_ofs.offset_serial_gate_n) begin
         ser_cnt_ff <= ser_cnt_ff + 1'b1;
         if (ser_cnt_ff == LAST_BIT) begin
            prog_ff <= PROG_DONE;
         end
      end else if (par_wr) begin
         par_cnt_ff <= par_cnt_ff + 1'b1;
         if (par_cnt_ff == LAST_PAR) begin
            prog_ff <= PROG_DONE;
         end
      end
   end

   // offset chain: serial bits enter at the bottom so the first bit ends as the top msb
   always_ff @(posedge i_mclk) begin
      if (i_sys_rst) begin
         ofs_ff <= {OFS_REGS{OFS_W'(OFS_RST)}};
      end else if (prog_ff == PROG_SERIAL && s_mr1_n && mr_prev_ff[1] && a_edge
                   && !s_ofs.offset_serial_gate_n) begin
         ofs_ff <= {ofs_ff[CHAIN_W-2:0], s_ofs.offset_serial_data};
      end else if (par_wr) begin
         ofs_ff[(OFS_REGS-1-int'(par_cnt_ff))*OFS_W +: OFS_W] <= par_word(s_a_data, ip_ff);
      end
   end

   // the controller keeps offsets within range; no check is made here
   assign o_fifo_one_almost_full_offset  = ofs_ff[(OFS_REGS-1-OFS_Y1)*OFS_W +: OFS_W];
   assign o_fifo_one_almost_empty_offset = ofs_ff[(OFS_REGS-1-OFS_X1)*OFS_W +: OFS_W];
   assign o_fifo_two_almost_full_offset  = ofs_ff[(OFS_REGS-1-OFS_Y2)*OFS_W +: OFS_W];
   assign o_fifo_two_almost_empty_offset = ofs_ff[(OFS_REGS-1-OFS_X2)*OFS_W +: OFS_W];

   // timing mode caught at the first port a edge after fifo one reset release
   always_ff @(posedge i_mclk) begin
      if (i_sys_rst) begin
         fall_through_mode_ff      <= 1'b0;
         mode_pend_ff <= 1'b1;
      end else if (!s_mr1_n) begin
         mode_pend_ff <= 1'b1;
      end else if (mode_pend_ff && a_edge) begin
         fall_through_mode_ff      <= !s_tms;
         mode_pend_ff <= 1'b0;
      end
   end

   // input ready flags refresh one cycle after their own port edge so a write
   // in that edge is already counted; low until offsets are programmed, except fifo one, which is also high in parallel programming
   // fifo one takes programming state at the edge itself, so the edge that shifts
   // the last serial bit leaves ready low and only the next one raises it
   always_ff @(posedge i_mclk) begin
      if (rst1) begin
         a_edge_d_ff <= 1'b0;
         ok1_ff      <= 1'b0;
         ir1_ff      <= 1'b0;
      end else begin
         a_edge_d_ff <= a_edge;
         if (a_edge) begin
            ok1_ff <= (prog_ff == PROG_DONE || prog_ff == PROG_PARALLEL);
         end
         if (a_edge_d_ff) begin
            ir1_ff <= f1_ready && ok1_ff;
         end
      end
   end

   always_ff @(posedge i_mclk) begin
      if (rst2) begin
         c_edge_d_ff <= 1'b0;
         ir2_ff      <= 1'b0;
      end else begin
         c_edge_d_ff <= c_edge;
         if (c_edge_d_ff) begin
            ir2_ff <= f2_ready && prog_ff == PROG_DONE;
         end
      end
   end

   // fifo one read side on port b edges; empty flag uses a two-edge pipeline
   always_ff @(posedge i_mclk) begin
      if (rst1) begin
         rdy1_ff   <= 1'b0;
         pre1_ff   <= 1'b0;
         data_b_ff <= '0;
      end else begin
         if (load1) begin
            data_b_ff <= f1_head[BC_W-1:0];
         end else if (b_mb_rd) begin
            data_b_ff <= mb1_ff;
         end
         if (b_edge) begin
            pre1_ff <= f1_valid;
            if (fall_through_mode_ff) begin
               rdy1_ff <= load1 || (rdy1_ff && !b_rd);
            end else begin
               rdy1_ff <= pre1_ff && (f1_cnt > (CW+1)'(load1));
            end
         end
      end
   end

   // fifo two read side on port a edges, loopback included
   always_ff @(posedge i_mclk) begin
      if (rst2) begin
         rdy2_ff   <= 1'b0;
         pre2_ff   <= 1'b0;
         seen2_ff  <= 1'b0;
         data_a_ff <= '0;
      end else begin
         if (load2) begin
            data_a_ff <= {{(A_W-BC_W){1'b0}}, f2_head};
            seen2_ff  <= 1'b1;
         end else if (a_mb_rd) begin
            data_a_ff <= {{(A_W-BC_W){1'b0}}, mb2_ff};
         end
         if (a_edge) begin
            pre2_ff <= f2_valid;
            if (fall_through_mode_ff) begin
               rdy2_ff <= load2 || (rdy2_ff && !a_rd);
            end else begin
               rdy2_ff <= pre2_ff && (f2_cnt > (CW+1)'(load2));
            end
         end
      end
   end

   // mailbox one: port a fills, port b empties; a fill in the same cycle wins
   always_ff @(posedge i_mclk) begin
      if (i_sys_rst) begin
         mb1_ff   <= '0;
         mb1_n_ff <= 1'b1;
      end else if (a_mb_wr) begin
         mb1_ff   <= s_a_data[BC_W-1:0];
         mb1_n_ff <= 1'b0;
      end else if (b_mb_rd) begin
         mb1_n_ff <= 1'b1;
      end
   end

   // mailbox two: port c fills, port a empties; a fill in the same cycle wins
   always_ff @(posedge i_mclk) begin
      if (i_sys_rst) begin
         mb2_ff   <= '0;
         mb2_n_ff <= 1'b1;
      end else if (c_mb_wr) begin
         mb2_ff   <= s_c_data;
         mb2_n_ff <= 1'b0;
      end else if (a_mb_rd) begin
         mb2_n_ff <= 1'b1;
      end
   end

   // bus drive enables follow the select pins, not the port clocks
   always_ff @(posedge i_mclk) begin
      if (i_sys_rst) begin
         oe_a_n_ff <= 1'b1;
         oe_b_n_ff <= 1'b1;
         done_ff   <= 1'b0;
      end else begin
         oe_a_n_ff <= s_a.port_a_select_n || s_a.port_a_direction;
         oe_b_n_ff <= s_b_sel_n;
         done_ff   <= (prog_ff == PROG_DONE);                         // status pin from a flop
      end
   end

   assign o_port_a_data              = data_a_ff;
   assign o_port_a_data_oe_n         = oe_a_n_ff;
   assign o_port_b_data              = data_b_ff;
   assign o_port_b_data_oe_n         = oe_b_n_ff;
   assign o_fifo_one_input_ready     = ir1_ff;
   assign o_fifo_two_input_ready     = ir2_ff;
   assign o_fifo_one_output_ready    = rdy1_ff;
   assign o_fifo_two_output_ready    = rdy2_ff;
   assign o_mailbox_one_full_n       = mb1_n_ff;
   assign o_mailbox_two_full_n       = mb2_n_ff;
   assign o_fall_through_mode        = fall_through_mode_ff;
   assign o_interspersed_parity_mode = ip_ff;
   assign o_offsets_programmed       = done_ff;
endmodule

// ### test/tpfpc_host_model.sv
// host side model: free-running port a, b and c clocks, 320 ns period
// assumes the bench drives the port pins itself between clock edges
`timescale 1ns/1ns
module tpfpc_host_model (
   output logic [2:0] o_pclk
);
   // distinct start offsets keep the port clock edges apart; each edge lands 10 ns before an mclk rise
   initial begin
      o_pclk = 3'h0;
      fork
         #10 forever #160 o_pclk[0] = ~o_pclk[0];
         #50 forever #160 o_pclk[1] = ~o_pclk[1];
         #130 forever #160 o_pclk[2] = ~o_pclk[2];
      join
   end
endmodule

// ### test/tpfpc_chk.sv
// checker for tpfpc_top: port enables, mailbox flags and offset programming
// assumes pins held stable at least four mclk around each port clock rise
`timescale 1ns/1ns
module tpfpc_chk
   import tpfpc_pkg::*;
#(parameter int OFS_W = 11) (
   // clock, reset and watched pins
   input wire logic             i_mclk, i_sys_rst, i_port_b_select_n, i_port_b_read_gate,
   input wire logic             i_port_b_mailbox_select, i_port_c_write_gate,
   input wire logic             i_port_c_mailbox_select, o_port_a_data_oe_n,
   input wire logic             o_port_b_data_oe_n, o_fifo_two_input_ready,
   input wire logic             o_offsets_programmed, o_mailbox_one_full_n, o_mailbox_two_full_n,
   input wire tpfpc_porta_ctl_s i_port_a_ctl,
   input wire logic [OFS_W-1:0] o_fifo_one_almost_full_offset
);
   logic [2:0] up_ff;
   // pin pipelines need a few cycles to refill after reset
   always_ff @(posedge i_mclk) begin
      if (i_sys_rst) up_ff <= 3'h0;
      else if (up_ff != 3'h7) up_ff <= up_ff + 3'h1;
   end
   default clocking cb @(posedge i_mclk); endclocking
   default disable iff (i_sys_rst);
   sequence s_settled;
      up_ff == 3'h7;
   endsequence
   AST_A_OE:
   assert property (s_settled ##0 $stable(i_port_a_ctl) [*4] |-> o_port_a_data_oe_n ==
      (i_port_a_ctl.port_a_select_n | i_port_a_ctl.port_a_direction)) else $error("a oe");
   AST_B_OE:
   assert property (s_settled ##0 $stable(i_port_b_select_n) [*4] |->
      o_port_b_data_oe_n == i_port_b_select_n) else $error("b oe");
   AST_MB1_SET:
   assert property (s_settled ##0 $fell(o_mailbox_one_full_n) |->
      $past(i_port_a_ctl, 3) == 4'h7) else $error("mb1 set");
   AST_MB1_CLR:
   assert property (s_settled ##0 $rose(o_mailbox_one_full_n) |-> !$past(i_port_b_select_n, 3)
      && $past(i_port_b_read_gate, 3) && $past(i_port_b_mailbox_select, 3)) else $error("mb1 clr");
   AST_MB2_SET:
   assert property (s_settled ##0 $fell(o_mailbox_two_full_n) |->
      $past(i_port_c_write_gate, 3) && $past(i_port_c_mailbox_select, 3)) else $error("mb2 set");
   AST_MB2_CLR:
   assert property (s_settled ##0 $rose(o_mailbox_two_full_n) |->
      $past(i_port_a_ctl, 3) == 4'h3) else $error("mb2 clr");
   AST_IR2_PROG:
   assert property (!o_offsets_programmed |-> !o_fifo_two_input_ready) else $error("ir2 early");
   AST_IR2_AFTER:
   assert property ($rose(o_offsets_programmed) |-> !o_fifo_two_input_ready [*2]) else $error("ir2");
   AST_OFS_HOLD:
   assert property (o_offsets_programmed && $past(o_offsets_programmed) |->
      $stable(o_fifo_one_almost_full_offset)) else $error("offset moved");
endmodule
bind tpfpc_top tpfpc_chk #(.OFS_W(OFS_W)) u_chk (.*);

// ### test/tb_triple_port_fifo_port_control.sv
// self-checking bench for tpfpc_top: serial offsets, fifo paths, mailboxes
// assumes the host model supplies free-running port clocks of 320 ns
`timescale 1ns/1ns
module tb_triple_port_fifo_port_control;
   import tpfpc_pkg::*;
   localparam int OFS_W = 11;
   logic i_mclk = 1'b0, i_sys_rst = 1'b1, i_wrap_select_n = 1'b1, i_timing_mode_select = 1'b0;
   logic i_port_b_select_n = 1'b1, i_port_b_read_gate = 1'b0, i_port_b_mailbox_select = 1'b0;
   logic i_port_c_write_gate = 1'b0, i_port_c_mailbox_select = 1'b0;
   logic i_fifo_one_master_reset_n = 1'b0, i_fifo_two_master_reset_n = 1'b0;
   logic [35:0] i_port_a_data = 36'h0;
   logic [17:0] i_port_c_data = 18'h0;
   tpfpc_porta_ctl_s i_port_a_ctl = 4'hc;
   tpfpc_ofs_pins_s i_ofs_pins = 3'h1; // flag high low, data low, gate high
   wire [35:0] o_port_a_data;
   wire [17:0] o_port_b_data;
   wire [2:0] pclk;
   wire i_port_a_clock, i_port_b_clock, i_port_c_clock, o_port_a_data_oe_n, o_port_b_data_oe_n;
   wire o_fifo_one_input_ready, o_fifo_two_input_ready, o_fifo_one_output_ready;
   wire o_fifo_two_output_ready, o_mailbox_one_full_n, o_mailbox_two_full_n;
   wire o_fall_through_mode, o_interspersed_parity_mode, o_offsets_programmed;
   wire [OFS_W-1:0] o_fifo_one_almost_full_offset, o_fifo_one_almost_empty_offset;
   wire [OFS_W-1:0] o_fifo_two_almost_full_offset, o_fifo_two_almost_empty_offset;
   int mismatches = 0, cmp_count = 0;
   logic [4*OFS_W-1:0] chain = {11'h005, 11'h003, 11'h006, 11'h002}; // in range
   assign {i_port_c_clock, i_port_b_clock, i_port_a_clock} = pclk;
   tpfpc_host_model host (.o_pclk(pclk));
   tpfpc_top #(.OFS_W(OFS_W), .DEPTH(8)) dut (.*);
   always #20 i_mclk = ~i_mclk;
   task automatic chk(string n, logic [43:0] got, logic [43:0] exp);
      cmp_count++;
      if (got !== exp) begin
         mismatches++;
         $display("[FAIL] %s expected %h seen %h", n, exp, got);
      end
   endtask
   // pins change at the first mclk fall after a port clock fall, well clear of the rise
   task automatic sync(int p);
      @(negedge pclk[p]);
      @(negedge i_mclk);
   endtask
   task automatic pa(tpfpc_porta_ctl_s c, logic [35:0] d);
      sync(0);
      {i_port_a_ctl, i_port_a_data} = {c, d};
      sync(0);
      chk("a_oe_n", o_port_a_data_oe_n, c.port_a_select_n | c.port_a_direction);
      i_port_a_ctl = 4'hc;
   endtask
   task automatic pb(logic g, logic m);
      sync(1);
      {i_port_b_select_n, i_port_b_read_gate, i_port_b_mailbox_select} = {1'b0, g, m};
      sync(1);
      chk("b_oe_n", o_port_b_data_oe_n, 1'b0);
      {i_port_b_select_n, i_port_b_read_gate, i_port_b_mailbox_select} = 3'h4;
   endtask
   task automatic pc(logic m, logic [17:0] d);
      sync(2);
      {i_port_c_write_gate, i_port_c_mailbox_select, i_port_c_data} = {1'b1, m, d};
      sync(2);
      i_port_c_write_gate = 1'b0;
   endtask
   task automatic conclude();
      $display("comparisons %0d mismatches %0d", cmp_count, mismatches);
      if (mismatches == 0 && cmp_count > 0) $display("Result: passed");
      else $display("Result: failed");
      $finish;
   endtask
   // hang guard
   initial begin
      repeat (20000) @(posedge i_mclk);
      mismatches++;
      conclude();
   end
   initial begin
      repeat (16) @(negedge i_mclk);
      i_sys_rst = 1'b0;
      repeat (4) @(negedge i_mclk);
      {i_fifo_one_master_reset_n, i_fifo_two_master_reset_n} = 2'h3;
      repeat (8) @(negedge i_mclk);
      for (int i = 4*OFS_W-1; i >= 0; i--) begin
         sync(0);
         i_ofs_pins = {1'b0, chain[i], 1'b0}; // msb first, 44 bits
      end
      sync(0);
      i_ofs_pins = 3'h1;
      chk("ir1_early", o_fifo_one_input_ready, 1'b0);
      repeat (2) sync(0);
      chk("chain", {o_fifo_one_almost_full_offset, o_fifo_one_almost_empty_offset,
         o_fifo_two_almost_full_offset, o_fifo_two_almost_empty_offset}, chain);
      chk("ready", {o_fifo_one_input_ready, o_fifo_two_input_ready, o_fall_through_mode,
         o_interspersed_parity_mode}, 4'he);
      $display("test serial programming done");
      pa(4'h6, 36'h000001111);
      pa(4'h6, 36'h000002222);
      chk("b_fall", {o_fifo_one_output_ready, o_port_b_data}, {1'b1, 18'h01111});
      pb(1'b1, 1'b0);
      chk("b_read", o_port_b_data, 18'h02222);
      $display("test fifo one path done");
      pa(4'h7, 36'h00000abcd);
      chk("mb1_full", o_mailbox_one_full_n, 1'b0);
      pb(1'b1, 1'b1);
      chk("mb1_read", {o_mailbox_one_full_n, o_port_b_data}, {1'b1, 18'h0abcd});
      pc(1'b1, 18'h01234);
      chk("mb2_full", o_mailbox_two_full_n, 1'b0);
      pa(4'h3, 36'h0);
      chk("mb2_read", {o_mailbox_two_full_n, o_port_a_data}, {1'b1, 36'h000001234});
      $display("test mailboxes done");
      pc(1'b0, 18'h00055);
      pa(4'h0, 36'h0);
      chk("a_fall", {o_fifo_two_output_ready, o_port_a_data}, {1'b1, 36'h000000055});
      pa(4'h2, 36'h0);
      chk("a_drain", o_fifo_two_output_ready, 1'b0);
      $display("test fifo two path done");
      pc(1'b0, 18'h00077);
      i_wrap_select_n = 1'b0;
      pa(4'h2, 36'h0);
      i_wrap_select_n = 1'b1;
      pb(1'b1, 1'b0);
      chk("loop", {o_fifo_one_output_ready, o_port_b_data}, {1'b1, 18'h00077});
      $display("test loopback done");
      conclude();
   end
endmodule
